// ### hdl/ulfm_line_filter.sv
// line state persistence filter: a change passes after 2^n stable clocks
`timescale 1ns/1ns
module ulfm_line_filter #(
    parameter int CNT_W = 16
) (
    // clock, reset, enable
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    input  wire logic             ce,
    // line state in (already synchronised) and filter setting
    input  wire logic [1:0]       ls_in,
    input  wire logic [3:0]       log2_clocks,
    // filtered line state
    output logic      [1:0]       ls_out
);

    // ************************************************************
    // elaboration check
    // ************************************************************
    if (CNT_W < 16)
    begin : g_bad_width
        $error("CNT_W must hold 2^15");
    end

    logic [1:0]       cand_reg;
    logic [1:0]       cand_next;
    logic [1:0]       out_reg;
    logic [1:0]       out_next;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic [CNT_W-1:0] limit;

    assign limit  = CNT_W'(32'(1) << log2_clocks);
    assign ls_out = out_reg;

    // any change of the candidate restarts the count, so a glitch
    // shorter than the window never reaches the flags
    always_comb
    begin
        cand_next = cand_reg;
        out_next  = out_reg;
        cnt_next  = cnt_reg;
        if (ls_in != cand_reg)
        begin
            cand_next = ls_in;
            cnt_next  = '0;
        end
        else if (cand_reg != out_reg)
        begin
            if (cnt_reg >= limit - CNT_W'(1))
            begin
                out_next = cand_reg;
                cnt_next = '0;
            end
            else
            begin
                cnt_next = cnt_reg + CNT_W'(1);
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            cand_reg <= ulfm_pkg::LS_SE0;
            out_reg  <= ulfm_pkg::LS_SE0;
            cnt_reg  <= '0;
        end
        else if (ce)
        begin
            cand_reg <= cand_next;
            out_reg  <= out_next;
            cnt_reg  <= cnt_next;
        end
    end

endmodule

// ### hdl/ulfm_top.sv
// usb link flag monitor: line/error flags, output masks and phy control
`timescale 1ns/1ns
module ulfm_top (
    // clock, reset, enable
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        ce,
    // peripheral register port, 32-bit words
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [31:0] reg_wdata,
    output logic      [31:0] reg_rdata,
    output logic             reg_rvalid,
    // transceiver pins
    input  wire logic [1:0]  utmi_linestate,
    input  wire logic        utmi_rxactive,
    input  wire logic        utmi_rxerror,
    output logic      [2:0]  transceiver_config_pins,
    // settings held elsewhere in the front end
    input  wire logic [6:0]  dev_addr,
    input  wire logic        lsd_enable,
    // packet path events
    input  wire logic        pkt_valid,
    input  wire logic [3:0]  pkt_pid,
    input  wire logic        tok_valid,
    input  wire logic        tok_crc_ok,
    input  wire logic        tok_pid_ok,
    input  wire logic [6:0]  tok_addr,
    input  wire logic [3:0]  tok_ep,
    input  wire logic        data_crc_fail,
    input  wire logic        sof_valid,
    input  wire logic [10:0] sof_frame,
    // suspend controller events
    input  wire logic        resume_se0,
    input  wire logic        resume_k,
    // outputs to ports and suspend controller
    output logic             flag_out_a,
    output logic             flag_out_b,
    output logic             flag_out_c,
    output logic [4:0]       rx_ep_port,
    output logic             rx_ep_strobe,
    output logic             byte_port_pd_disable,
    output logic             auto_resume_enable,
    output logic [1:0]       linestate_filt,
    output logic [7:0]       pwr_data,
    output logic             pwr_valid
);

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    logic [1:0] ls_s1_reg;
    logic [1:0] ls_s2_reg;
    logic       rxa_s1_reg;
    logic       rxa_s2_reg;
    logic       rxe_s1_reg;
    logic       rxe_s2_reg;
    logic [1:0] ls_filt;

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            ls_s1_reg  <= 2'h0;
            ls_s2_reg  <= 2'h0;
            rxa_s1_reg <= 1'b0;
            rxa_s2_reg <= 1'b0;
            rxe_s1_reg <= 1'b0;
            rxe_s2_reg <= 1'b0;
        end
        else if (ce)
        begin
            ls_s1_reg  <= utmi_linestate;
            ls_s2_reg  <= ls_s1_reg;
            rxa_s1_reg <= utmi_rxactive;
            rxa_s2_reg <= rxa_s1_reg;
            rxe_s1_reg <= utmi_rxerror;
            rxe_s2_reg <= rxe_s1_reg;
        end
    end

    // ************************************************************
    // state
    // ************************************************************
    logic [6:0]  flags_reg;
    logic [6:0]  flags_next;
    logic [6:0]  persist_reg;
    logic [6:0]  persist_next;
    logic [22:0] omask_reg;
    logic [22:0] omask_next;
    logic [10:0] frame_reg;
    logic [10:0] frame_next;
    logic [3:0]  pid_reg;
    logic [3:0]  pid_next;
    logic [4:0]  ep_reg;
    logic [4:0]  ep_next;
    logic [15:0] epmark_reg;
    logic [15:0] epmark_next;
    logic [8:0]  pwr_reg;
    logic [8:0]  pwr_next;
    logic [18:0] phy_reg;
    logic [18:0] phy_next;
    logic [2:0]  fout_reg;
    logic [2:0]  fout_next;
    logic [4:0]  rxport_reg;
    logic [4:0]  rxport_next;
    logic        rxstb_reg;
    logic        rxstb_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic        rvalid_reg;

    ulfm_line_filter #(
        .CNT_W       (16)
    ) u_filter (
        .clk_sys     (clk_sys),
        .rst_n       (rst_n),
        .ce          (ce),
        .ls_in       (ls_s2_reg),
        .log2_clocks (phy_reg[ulfm_pkg::PHY_LOG_LSB +: 4]),
        .ls_out      (ls_filt)
    );

    // ************************************************************
    // flag sources
    // ************************************************************
    logic       tok_hit;
    logic [6:0] src;
    logic [6:0] wclr;
    logic       wr_flags;

    // tokens for other addresses are dropped here, not flagged
    assign tok_hit = tok_valid & tok_crc_ok & tok_pid_ok
                   & (tok_addr == dev_addr);
    assign src[ulfm_pkg::FLG_TOKEN_OK] = tok_hit;
    assign src[ulfm_pkg::FLG_SE0] = lsd_enable
                   & (ls_filt == ulfm_pkg::LS_SE0);
    assign src[ulfm_pkg::FLG_K]   = lsd_enable
                   & (ls_filt == ulfm_pkg::LS_K);
    assign src[ulfm_pkg::FLG_J]   = lsd_enable
                   & (ls_filt == ulfm_pkg::LS_J);
    assign src[ulfm_pkg::FLG_CRC16]    = data_crc_fail;
    assign src[ulfm_pkg::FLG_RXACTIVE] = rxa_s2_reg;
    assign src[ulfm_pkg::FLG_RXERROR]  = rxe_s2_reg;

    assign wr_flags = reg_wr && (reg_addr == ulfm_pkg::OFS_LINE_EVENT_FLAGS);
    assign wclr     = wr_flags ? reg_wdata[6:0] : 7'h00;

    // a new source value always beats a clear in the same cycle
    for (genvar i = 0; i < ulfm_pkg::NUM_FLAGS; i++)
    begin : g_flag
        if (ulfm_pkg::FLAG_EVENT_KIND[i])
        begin : g_event
            assign flags_next[i] = persist_reg[i]
                ? (src[i] | (flags_reg[i] & ~wclr[i]))
                : (src[i] | (flags_reg[i] & ~wclr[i]
                             & ~pkt_valid));
        end
        else
        begin : g_level
            assign flags_next[i] = persist_reg[i]
                ? (src[i] | (flags_reg[i] & ~wclr[i]))
                : src[i];
        end
    end

    // ************************************************************
    // register writes, captures and outputs
    // ************************************************************
    always_comb
    begin
        persist_next = persist_reg;
        omask_next   = omask_reg;
        frame_next   = frame_reg;
        pid_next     = pid_reg;
        ep_next      = ep_reg;
        epmark_next  = epmark_reg;
        pwr_next     = pwr_reg;
        phy_next     = phy_reg;
        rxport_next  = rxport_reg;
        rxstb_next   = 1'b0;
        if (reg_wr)
        begin
            unique case (reg_addr)
                ulfm_pkg::OFS_FLAG_PERSISTENCE_MASK:
                    persist_next = reg_wdata[6:0];
                ulfm_pkg::OFS_FLAG_OUTPUT_MASKS:
                    omask_next = reg_wdata[22:0] & 23'h7f7f7f;
                ulfm_pkg::OFS_FRAME_NUMBER:
                    frame_next = reg_wdata[10:0];
                ulfm_pkg::OFS_ENDPOINT_SPECIAL_MASK:
                    epmark_next = reg_wdata[15:0];
                ulfm_pkg::OFS_POWER_SIGNAL_DATA:
                    pwr_next = reg_wdata[8:0];
                ulfm_pkg::OFS_TRANSCEIVER_CONTROL:
                    phy_next = reg_wdata[18:0] & 19'h43ff0;
                default:
                    ;
            endcase
        end
        // the frame seen on the wire wins over a software write
        if (sof_valid)
            frame_next = sof_frame;
        if (pkt_valid)
            pid_next = pkt_pid;
        if (tok_hit)
        begin
            ep_next     = {1'b1, tok_ep};
            rxport_next = epmark_reg[tok_ep]
                ? ({1'b0, tok_ep} | ulfm_pkg::EP_MARK)
                : {1'b0, tok_ep};
            rxstb_next  = 1'b1;
        end
        // resume status set beats a software clear in the same cycle
        if (resume_se0)
            phy_next[ulfm_pkg::PHY_RES_SE0_BIT] = 1'b1;
        if (resume_k)
            phy_next[ulfm_pkg::PHY_RES_K_BIT] = 1'b1;
        // outputs built from next flags so they move with the flags
        fout_next[0] = |(flags_next & omask_reg[6:0]);
        fout_next[1] = |(flags_next & omask_reg[14:8]);
        fout_next[2] = |(flags_next & omask_reg[22:16]);
    end

    // ************************************************************
    // read data
    // ************************************************************
    always_comb
    begin
        rdata_next = 32'h00000000;
        unique case (reg_addr)
            ulfm_pkg::OFS_LINE_EVENT_FLAGS:
                rdata_next = {25'h0, flags_reg};
            ulfm_pkg::OFS_FLAG_PERSISTENCE_MASK:
                rdata_next = {25'h0, persist_reg};
            ulfm_pkg::OFS_FLAG_OUTPUT_MASKS:
                rdata_next = {9'h0, omask_reg};
            ulfm_pkg::OFS_FRAME_NUMBER:
                rdata_next = {21'h0, frame_reg};
            ulfm_pkg::OFS_LAST_PACKET_ID:
                rdata_next = {28'h0, pid_reg};
            ulfm_pkg::OFS_LAST_ENDPOINT:
                rdata_next = {27'h0, ep_reg};
            ulfm_pkg::OFS_ENDPOINT_SPECIAL_MASK:
                rdata_next = {16'h0, epmark_reg};
            ulfm_pkg::OFS_POWER_SIGNAL_DATA:
                rdata_next = {23'h0, pwr_reg};
            ulfm_pkg::OFS_TRANSCEIVER_CONTROL:
                rdata_next = {13'h0, phy_reg};
            default:
                rdata_next = 32'h00000000;
        endcase
        if (!reg_rd)
            rdata_next = rdata_reg;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            flags_reg   <= ulfm_pkg::FLAGS_RST;
            persist_reg <= ulfm_pkg::PERSIST_RST;
            omask_reg   <= ulfm_pkg::OMASK_RST;
            frame_reg   <= ulfm_pkg::FRAME_RST;
            pid_reg     <= ulfm_pkg::PID_RST;
            ep_reg      <= ulfm_pkg::EP_RST;
            epmark_reg  <= ulfm_pkg::EPMARK_RST;
            pwr_reg     <= ulfm_pkg::PWR_RST;
            phy_reg     <= ulfm_pkg::PHY_RST;
            fout_reg    <= 3'h0;
            rxport_reg  <= 5'h00;
            rxstb_reg   <= 1'b0;
            rdata_reg   <= 32'h00000000;
            rvalid_reg  <= 1'b0;
        end
        else if (ce)
        begin
            flags_reg   <= flags_next;
            persist_reg <= persist_next;
            omask_reg   <= omask_next;
            frame_reg   <= frame_next;
            pid_reg     <= pid_next;
            ep_reg      <= ep_next;
            epmark_reg  <= epmark_next;
            pwr_reg     <= pwr_next;
            phy_reg     <= phy_next;
            fout_reg    <= fout_next;
            rxport_reg  <= rxport_next;
            rxstb_reg   <= rxstb_next;
            rdata_reg   <= rdata_next;
            rvalid_reg  <= reg_rd;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign reg_rdata               = rdata_reg;
    assign reg_rvalid              = rvalid_reg;
    assign flag_out_a              = fout_reg[0];
    assign flag_out_b              = fout_reg[1];
    assign flag_out_c              = fout_reg[2];
    assign rx_ep_port              = rxport_reg;
    assign rx_ep_strobe            = rxstb_reg;
    assign pwr_data                = pwr_reg[7:0];
    assign pwr_valid               = pwr_reg[ulfm_pkg::PWR_VALID_BIT];
    assign byte_port_pd_disable    = phy_reg[ulfm_pkg::PHY_PD_DIS_BIT];
    assign auto_resume_enable      = phy_reg[ulfm_pkg::PHY_AUTO_BIT];
    assign transceiver_config_pins = phy_reg[6:4];
    assign linestate_filt          = ls_filt;

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    token_flag_a: assert property (ce && tok_hit |=> flags_reg[6])
        else $error("good token did not set flag 6");
    crc_flag_a: assert property (ce && data_crc_fail |=> flags_reg[2])
        else $error("crc16 failure did not set flag 2");
    rxact_follow_a: assert property (ce && !persist_reg[1]
        |=> flags_reg[1] == $past(rxa_s2_reg))
        else $error("flag 1 does not follow rx active");
    packet_clear_a: assert property (ce && pkt_valid && !persist_reg[2]
        && !data_crc_fail |=> !flags_reg[2])
        else $error("non-persistent flag survived a new packet");
    sticky_hold_a: assert property (ce && persist_reg[6] && flags_reg[6]
        && !wclr[6] |=> flags_reg[6])
        else $error("persistent flag lost without a clear");
    flag_out_a_a: assert property (ce ##1 1'b1
        |-> flag_out_a == |(flags_reg & omask_reg[6:0]) || $changed(omask_reg))
        else $error("flag output a disagrees with its flags");
    resume_se0_a: assert property (ce && resume_se0 |=> phy_reg[13])
        else $error("se0 auto resume not recorded");
    endpoint_mark_a: assert property (ce && tok_hit |=> rx_ep_strobe
        && rx_ep_port[4] == $past(epmark_reg[tok_ep]))
        else $error("endpoint mark not applied to receive port");
    config_pins_a: assert property (ce && reg_wr
        && reg_addr == ulfm_pkg::OFS_TRANSCEIVER_CONTROL
        |=> transceiver_config_pins == $past(reg_wdata[6:4]))
        else $error("config pins differ from control bits");

endmodule

// ### pkg/ulfm_pkg.sv
// register map, field layout and reset values of the usb link flag monitor
package ulfm_pkg;

    // ************************************************************
    // register offsets (byte addresses on the peripheral port)
    // ************************************************************
    localparam logic [7:0] OFS_LINE_EVENT_FLAGS      = 8'h1c;
    localparam logic [7:0] OFS_FLAG_PERSISTENCE_MASK = 8'h20;
    localparam logic [7:0] OFS_FLAG_OUTPUT_MASKS     = 8'h24;
    localparam logic [7:0] OFS_FRAME_NUMBER          = 8'h28;
    localparam logic [7:0] OFS_LAST_PACKET_ID        = 8'h2c;
    localparam logic [7:0] OFS_LAST_ENDPOINT         = 8'h30;
    localparam logic [7:0] OFS_ENDPOINT_SPECIAL_MASK = 8'h34;
    localparam logic [7:0] OFS_POWER_SIGNAL_DATA     = 8'h38;
    localparam logic [7:0] OFS_TRANSCEIVER_CONTROL   = 8'h3c;

    // ************************************************************
    // flag bits of line_event_flags
    // ************************************************************
    localparam int NUM_FLAGS    = 7;
    localparam int FLG_TOKEN_OK = 6;
    localparam int FLG_SE0      = 5;
    localparam int FLG_K        = 4;
    localparam int FLG_J        = 3;
    localparam int FLG_CRC16    = 2;
    localparam int FLG_RXACTIVE = 1;
    localparam int FLG_RXERROR  = 0;
    // flags raised by a one-cycle event rather than following a level
    localparam logic [6:0] FLAG_EVENT_KIND = 7'h44;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int MASK_C_LSB      = 16;
    localparam int MASK_B_LSB      = 8;
    localparam int MASK_A_LSB      = 0;
    localparam int FRAME_W         = 11;
    localparam int PID_W           = 4;
    localparam int EP_W            = 4;
    localparam int EP_VALID_BIT    = 4;
    localparam logic [4:0] EP_MARK = 5'h10;
    localparam int NUM_EP          = 16;
    localparam int PWR_VALID_BIT   = 8;
    localparam int PHY_PD_DIS_BIT  = 18;
    localparam int PHY_RES_SE0_BIT = 13;
    localparam int PHY_RES_K_BIT   = 12;
    localparam int PHY_LOG_LSB     = 8;
    localparam int PHY_AUTO_BIT    = 7;
    localparam int PHY_CONF_LSB    = 4;
    localparam int ADDR_W          = 7;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [6:0]  FLAGS_RST   = 7'h00;
    localparam logic [6:0]  PERSIST_RST = 7'h00;
    localparam logic [22:0] OMASK_RST   = 23'h000000;
    localparam logic [10:0] FRAME_RST   = 11'h000;
    localparam logic [3:0]  PID_RST     = 4'h0;
    localparam logic [4:0]  EP_RST      = 5'h00;
    localparam logic [15:0] EPMARK_RST  = 16'h0000;
    localparam logic [8:0]  PWR_RST     = 9'h000;
    localparam logic [18:0] PHY_RST     = 19'h00000;

    // ************************************************************
    // line state codes
    // ************************************************************
    localparam logic [1:0] LS_SE0 = 2'h0;
    localparam logic [1:0] LS_J   = 2'h1;
    localparam logic [1:0] LS_K   = 2'h2;

endpackage

// ### sim/ulfm_phy_model.sv
// transceiver model driving line state and receive status pins
`timescale 1ns/1ns
module ulfm_phy_model (
    // clock
    input  wire logic       clk_sys,
    // pin levels asked for by the bench
    input  wire logic [1:0] ls_req,
    input  wire logic       act_req,
    input  wire logic       err_req,
    // transceiver pins
    output logic      [1:0] utmi_linestate,
    output logic            utmi_rxactive,
    output logic            utmi_rxerror
);
    // pins move just after a rising edge, as a real transceiver launches them
    initial {utmi_linestate, utmi_rxactive, utmi_rxerror} = '0;
    always @(posedge clk_sys)
    begin
        {utmi_linestate, utmi_rxactive, utmi_rxerror} <= {ls_req, act_req, err_req};
    end
endmodule

// ### sim/ulfm_tb_top.sv
// self-checking bench of the usb link flag monitor
`timescale 1ns/1ns
module ulfm_tb_top;
    // ********************
    // signals and helpers
    // ********************
    logic        clk_sys, rst_n, ce, reg_wr, reg_rd, reg_rvalid, lsd_enable;
    logic        utmi_rxactive, utmi_rxerror, pkt_valid, tok_valid, tok_ok;
    logic        data_crc_fail, sof_valid, resume_se0, resume_k, pwr_valid;
    logic        flag_out_a, flag_out_b, flag_out_c, rx_ep_strobe, act, err;
    logic        byte_port_pd_disable, auto_resume_enable;
    logic [1:0]  utmi_linestate, linestate_filt, ls;
    logic [2:0]  transceiver_config_pins;
    logic [3:0]  pkt_pid, tok_ep;
    logic [4:0]  rx_ep_port;
    logic [6:0]  dev_addr, tok_addr;
    logic [7:0]  reg_addr, pwr_data;
    logic [10:0] sof_frame;
    logic [31:0] reg_wdata, reg_rdata, seed, v, phy;
    int          err_total, tests_run, i, n;
    localparam logic [7:0]  OFS [8] = '{8'h20, 8'h24, 8'h28, 8'h2c, 8'h30,
                                        8'h34, 8'h40, 8'h38};
    localparam logic [31:0] MSK [8] = '{32'h7f, 32'h7f7f7f, 32'h7ff, 32'h0,
                                        32'h0, 32'hffff, 32'h0, 32'h1ff};

    ulfm_phy_model i_phy (.clk_sys, .ls_req(ls), .act_req(act), .err_req(err),
        .utmi_linestate, .utmi_rxactive, .utmi_rxerror);
    ulfm_top i_dut (.clk_sys, .rst_n, .ce, .reg_addr, .reg_wr, .reg_rd,
        .reg_wdata, .reg_rdata, .reg_rvalid, .utmi_linestate, .utmi_rxactive,
        .utmi_rxerror, .transceiver_config_pins, .dev_addr, .lsd_enable,
        .pkt_valid, .pkt_pid, .tok_valid, .tok_crc_ok(tok_ok),
        .tok_pid_ok(tok_ok), .tok_addr, .tok_ep, .data_crc_fail, .sof_valid,
        .sof_frame, .resume_se0, .resume_k, .flag_out_a, .flag_out_b,
        .flag_out_c, .rx_ep_port, .rx_ep_strobe, .byte_port_pd_disable,
        .auto_resume_enable, .linestate_filt, .pwr_data, .pwr_valid);

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [31:0] ls_exp(logic [1:0] l, logic a, logic e);
        logic [31:0] r;
        r = {30'h0, a, e};
        r[l == ulfm_pkg::LS_SE0 ? 5 : (l == ulfm_pkg::LS_K ? 4 : 3)] = 1'b1;
        return r;
    endfunction
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic pulse(ref logic s);
        @(negedge clk_sys);
        s = 1'b1;
        @(negedge clk_sys);
        s = 1'b0;
    endtask
    task automatic wreg(logic [7:0] a, logic [31:0] d);
        @(negedge clk_sys);
        {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
        @(negedge clk_sys);
        reg_wr = 1'b0;
    endtask
    // read answers exactly one edge after the strobe is taken
    task automatic rreg(logic [7:0] a, logic [31:0] e);
        @(negedge clk_sys);
        {reg_addr, reg_rd} = {a, 1'b1};
        @(negedge clk_sys);
        reg_rd = 1'b0;
        chk("reg_rvalid", 1, reg_rvalid);
        chk($sformatf("reg %h", a), e, reg_rdata);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // ********************
    // clock and sequence
    // ********************
    initial
    begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    initial
    begin
        {reg_wr, reg_rd, lsd_enable, act, err, pkt_valid, tok_valid} = '0;
        {tok_ok, data_crc_fail, sof_valid, resume_se0, resume_k} = '0;
        {pkt_pid, tok_ep, dev_addr, tok_addr, reg_addr, sof_frame} = '0;
        {reg_wdata, err_total, tests_run, rst_n, ce} = {96'h0, 2'b01};
        {seed, ls} = {32'h681d, ulfm_pkg::LS_J};
        repeat (4) @(negedge clk_sys);
        rst_n = 1'b1;
        // line stays J but the decoder is off, so flags must stay clear
        for (i = 0; i < 9; i++)
            rreg(8'h1c + 8'(4 * i), 32'h0);
        chk("outs", 0, {flag_out_a, flag_out_b, flag_out_c, pwr_data});
        $display("test reset done");
        for (i = 0; i < 8; i++)
        begin
            v = xs();
            wreg(OFS[i], v);
            rreg(OFS[i], v & MSK[i]);
        end
        chk("pwr", v[8:0], {pwr_valid, pwr_data});
        v = xs();
        phy = v & 32'h0004_00f0;
        wreg(ulfm_pkg::OFS_TRANSCEIVER_CONTROL, v & 32'hffff_c0ff);
        rreg(ulfm_pkg::OFS_TRANSCEIVER_CONTROL, phy);
        chk("pins", {phy[18], phy[7:4]}, {byte_port_pd_disable,
            auto_resume_enable, transceiver_config_pins});
        $display("test registers done");
        v = xs();
        {dev_addr, tok_ep, tok_ok, tok_addr} = {v[6:0], v[11:8], 1'b1, ~v[6:0]};
        wreg(ulfm_pkg::OFS_ENDPOINT_SPECIAL_MASK, {16'h0, v[31:16]});
        wreg(ulfm_pkg::OFS_FLAG_PERSISTENCE_MASK, 32'h0);
        wreg(ulfm_pkg::OFS_FLAG_OUTPUT_MASKS, 32'h0002_0440);
        pulse(tok_valid);
        chk("strobe_miss", 0, {rx_ep_strobe, flag_out_a});
        {tok_ok, tok_addr} = {1'b0, dev_addr};
        pulse(tok_valid);
        chk("strobe_bad", 0, {rx_ep_strobe, flag_out_a});
        tok_ok = 1'b1;
        pulse(tok_valid);
        chk("rx_ep_port", {v[16 + tok_ep], tok_ep}, rx_ep_port);
        chk("strobe_hit", 2'b11, {rx_ep_strobe, flag_out_a});
        rreg(ulfm_pkg::OFS_LAST_ENDPOINT, {27'h1, tok_ep});
        rreg(ulfm_pkg::OFS_LINE_EVENT_FLAGS, 32'h40);
        pkt_pid = v[15:12];
        pulse(pkt_valid);
        rreg(ulfm_pkg::OFS_LINE_EVENT_FLAGS, 32'h0);
        rreg(ulfm_pkg::OFS_LAST_PACKET_ID, {28'h0, pkt_pid});
        wreg(ulfm_pkg::OFS_FLAG_PERSISTENCE_MASK, 32'h44);
        pulse(tok_valid);
        pulse(pkt_valid);
        pulse(data_crc_fail);
        chk("flag_out_b", 1, flag_out_b);
        rreg(ulfm_pkg::OFS_LINE_EVENT_FLAGS, 32'h44);
        wreg(ulfm_pkg::OFS_LINE_EVENT_FLAGS, 32'h40);
        rreg(ulfm_pkg::OFS_LINE_EVENT_FLAGS, 32'h04);
        $display("test token done");
        wreg(ulfm_pkg::OFS_FLAG_PERSISTENCE_MASK, 32'h0);
        wreg(ulfm_pkg::OFS_LINE_EVENT_FLAGS, 32'h7f);
        lsd_enable = 1'b1;
        // eight stable clocks before a line change may pass the filter
        phy = phy | 32'h0300;
        wreg(ulfm_pkg::OFS_TRANSCEIVER_CONTROL, phy);
        for (i = 0; i < 3; i++)
        begin
            v = xs();
            {err, act, ls} = {v[1:0], 2'(i)};
            repeat (9) @(negedge clk_sys);
            chk("filt_early", 1, linestate_filt !== ls);
            for (n = 0; n < 40 && linestate_filt !== ls; n++)
                @(negedge clk_sys);
            if (linestate_filt !== ls)
            begin
                err_total++;
                conclude();
            end
            repeat (4) @(negedge clk_sys);
            rreg(8'h1c, ls_exp(ls, act, err));
            chk("flag_out_c", act, flag_out_c);
        end
        $display("test line done");
        pulse(resume_se0);
        rreg(ulfm_pkg::OFS_TRANSCEIVER_CONTROL, phy | 32'h2000);
        pulse(resume_k);
        rreg(ulfm_pkg::OFS_TRANSCEIVER_CONTROL, phy | 32'h3000);
        wreg(ulfm_pkg::OFS_TRANSCEIVER_CONTROL, phy | 32'h1000);
        rreg(ulfm_pkg::OFS_TRANSCEIVER_CONTROL, phy | 32'h1000);
        wreg(ulfm_pkg::OFS_TRANSCEIVER_CONTROL, phy);
        rreg(ulfm_pkg::OFS_TRANSCEIVER_CONTROL, phy);
        sof_frame = v[26:16];
        pulse(sof_valid);
        rreg(ulfm_pkg::OFS_FRAME_NUMBER, {21'h0, sof_frame});
        @(negedge clk_sys);
        rst_n = 1'b0;
        @(negedge clk_sys);
        rst_n = 1'b1;
        rreg(ulfm_pkg::OFS_FRAME_NUMBER, 32'h0);
        rreg(ulfm_pkg::OFS_LAST_ENDPOINT, 32'h0);
        $display("test resume and frame done");
        conclude();
    end
endmodule
